// >>> hw/dsr_pkg.sv
//==============================================================
// Summary of operation
// - Two-wire address is 110100 plus select pin
// - Select low answers 1101000, high 1101001
// - Slave drives SDA low during ninth clock
// - Bus busy START to STOP, repeated START readdresses
// - Eight-bit bytes, each acknowledged, unlimited count
// - Slave may hold SCL low; master waits
// - SDA changes only while SCL low
// - Write: address, index, data, each acknowledged
// - Burst write increments index per data byte
// - Read: index write, repeated START, read bytes
// - Master NACK then STOP ends read driving
// - Chip select frames SPI; SDO released when high
// - SPI bytes move most significant bit first
// - SPI samples on rising, shifts on falling
// - SPI command byte: direction, seven-bit index
// - SPI takes single or burst data bytes
//==============================================================
package dsr_pkg;

   // ===========================================================
   // Widths and codes
   localparam int REG_IDX_W = 8;
   localparam logic [5:0] TWO_WIRE_ADDR_HI = 6'h34;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [2:0] SPI_LAST_BIT = 3'h7;
   localparam logic [2:0] TX_LAST_BIT = 3'h7;
   localparam logic DIR_READ = 1'b1;

   // ===========================================================
   // Link rate limits kept by the master
   localparam int TWO_WIRE_MAX_KHZ = 400;
   localparam int SPI_MAX_KHZ = 8000;

   // ===========================================================
   // State types
   typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_FETCH, I_TX, I_MACK} dsr_i2c_st_t;
   typedef enum logic [1:0] {K_ADDR, K_INDEX, K_DATA} dsr_kind_t;

endpackage

// >>> hw/dsr_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser; lines idle high so reset is all ones
module dsr_sync #(
   parameter int W = 1
) (
   input wire logic core_clk_i,     // Core clock
   input wire logic srst_i,         // Synchronous reset
   input wire logic [W-1:0] din_i,  // Asynchronous inputs
   output logic [W-1:0] dout_o      // Synchronised levels
);
   logic [W-1:0] meta;

   // ===========================================================
   // First stage feeds only the second stage
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         meta <= '1;
         dout_o <= '1;
      end else begin
         meta <= din_i;
         dout_o <= meta;
      end
   end
endmodule
`default_nettype wire

// >>> hw/dsr_spi_engine.sv
`timescale 1ns/10ps
`default_nettype none
// Four-wire slave engine working on oversampled pin levels
module dsr_spi_engine
   import dsr_pkg::*;
(
   input wire logic core_clk_i,                 // Core clock
   input wire logic srst_i,                     // Synchronous reset
   input wire logic sclk_s_i,                   // Synchronised serial clock
   input wire logic sdi_s_i,                    // Synchronised serial input
   input wire logic cs_n_s_i,                   // Synchronised chip select
   input wire logic [7:0] reg_rdata_i,          // Read data, cycle after request
   output logic [REG_IDX_W-1:0] reg_index_o,    // Register index
   output logic [7:0] reg_wdata_o,              // Write data
   output logic reg_wr_o,                       // Write pulse
   output logic reg_rd_o,                       // Read request pulse
   output logic sdo_o,                          // Serial output
   output logic sdo_oe_n_o                      // Output enable, low drives
);
   logic sclk_q;
   logic [2:0] cnt;
   logic [6:0] sh;
   logic [7:0] tx;
   logic [7:0] out_sh;
   logic first;
   logic rw;
   logic ld;
   logic sclk_rise;
   logic sclk_fall;
   logic [7:0] byte_in;

   assign sclk_rise = sclk_s_i & ~sclk_q;
   assign sclk_fall = ~sclk_s_i & sclk_q;
   assign byte_in = {sh, sdi_s_i};

   // ===========================================================
   // Receive side: command byte, then data bytes until deselect
   always_ff @(posedge core_clk_i) begin
      sclk_q <= sclk_s_i;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      ld <= reg_rd_o;
      if (srst_i) begin
         cnt <= 3'h0;
         sh <= 7'h00;
         first <= 1'b1;
         rw <= 1'b0;
         ld <= 1'b0;
         tx <= 8'h00;
         reg_index_o <= '0;
         reg_wdata_o <= 8'h00;
      end else if (cs_n_s_i) begin
         cnt <= 3'h0;
         first <= 1'b1;
      end else begin
         if (sclk_rise) begin
            sh <= byte_in[6:0];
            cnt <= cnt + 3'h1;
            if (cnt == SPI_LAST_BIT) begin
               if (first) begin
                  first <= 1'b0;
                  rw <= byte_in[7];
                  reg_index_o <= {1'b0, byte_in[6:0]};
                  reg_rd_o <= (byte_in[7] == DIR_READ);
               end else if (rw == DIR_READ) begin
                  reg_rd_o <= 1'b1; // prefetch next byte
               end else begin
                  reg_wdata_o <= byte_in;
                  reg_wr_o <= 1'b1;
               end
            end
         end
         // Index moves after each write and each fetched byte
         if (reg_wr_o || ld) begin
            reg_index_o <= reg_index_o + 1'b1;
         end
         if (ld) begin
            tx <= reg_rdata_i;
         end
      end
   end

   // ===========================================================
   // Output shifts only on falling edges; needs half period of 3+ core cycles
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sdo_o <= 1'b0;
         out_sh <= 8'h00;
         sdo_oe_n_o <= 1'b1;
      end else begin
         sdo_oe_n_o <= cs_n_s_i;
         if (!cs_n_s_i && sclk_fall) begin
            if (cnt == 3'h0) begin
               sdo_o <= tx[7];
               out_sh <= {tx[6:0], 1'b0};
            end else begin
               sdo_o <= out_sh[7];
               out_sh <= {out_sh[6:0], 1'b0};
            end
         end
      end
   end

   // ===========================================================
   // Checks
   property p_spi_oe_off;
      @(posedge core_clk_i) disable iff (srst_i) cs_n_s_i |=> sdo_oe_n_o;
   endproperty
   a_spi_oe_off: assert property (p_spi_oe_off) else $error("SDO driven while deselected");

   property p_spi_fall_only;
      @(posedge core_clk_i) disable iff (srst_i) $changed(sdo_o) |-> $past(sclk_fall);
   endproperty
   a_spi_fall_only: assert property (p_spi_fall_only) else $error("SDO moved off a falling edge");

   property p_spi_inc;
      @(posedge core_clk_i) disable iff (srst_i)
         (reg_wr_o && !cs_n_s_i) |=> (reg_index_o == $past(reg_index_o) + 1'b1);
   endproperty
   a_spi_inc: assert property (p_spi_inc) else $error("SPI index did not advance");

   property p_spi_fetch;
      @(posedge core_clk_i) disable iff (srst_i)
         (sclk_rise && !cs_n_s_i && first && cnt == SPI_LAST_BIT && sh[6])
         |=> reg_rd_o;
   endproperty
   a_spi_fetch: assert property (p_spi_fetch) else $error("SPI read command not fetched");

   c_spi_write: cover property (@(posedge core_clk_i) reg_wr_o ##[1:400] reg_wr_o);
   c_spi_read: cover property (@(posedge core_clk_i) ld ##[1:400] ld);
endmodule
`default_nettype wire

// >>> hw/dsr_serial_slave.sv
`timescale 1ns/10ps
`default_nettype none
// Shared-pin serial register port: two-wire slave or four-wire SPI slave
module dsr_serial_slave
   import dsr_pkg::*;
(
   input wire logic core_clk_i,                 // Core clock, 20 MHz
   input wire logic srst_i,                     // Synchronous reset, high
   input wire logic scl_sclk_i,                 // SCL or SCLK pin level
   input wire logic sda_sdi_i,                  // SDA or SDI pin level
   input wire logic cs_n_i,                     // SPI chip select pin
   input wire logic address_select_pin_i,       // Address LSB pin level
   input wire logic two_wire_disable_bit_i,     // From register file
   output logic sda_o,                          // SDA output value, always 0
   output logic sda_oe_n_o,                     // SDA enable, low pulls down
   output logic scl_o,                          // SCL output value, always 0
   output logic scl_oe_n_o,                     // SCL enable, low stretches
   output logic sdo_o,                          // SPI serial output
   output logic sdo_oe_n_o,                     // SDO enable, low drives
   output logic [REG_IDX_W-1:0] reg_index_o,    // Register index
   output logic [7:0] reg_wdata_o,              // Write data
   output logic reg_wr_o,                       // Write pulse
   output logic reg_rd_o,                       // Read request pulse
   input wire logic [7:0] reg_rdata_i           // Read data, cycle after request
);
   logic scl_s;
   logic sda_s;
   logic cs_n_s;
   logic ad_sel_s;
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic tw_en;
   dsr_i2c_st_t state;
   dsr_kind_t kind;
   logic [3:0] cnt;
   logic [7:0] sh;
   logic rw;
   logic more;
   logic i_wr;
   logic i_rd;
   logic [REG_IDX_W-1:0] i_index;
   logic [7:0] i_wdata;
   logic [REG_IDX_W-1:0] s_index;
   logic [7:0] s_wdata;
   logic s_wr;
   logic s_rd;

   // ===========================================================
   // Pin synchronisers
   dsr_sync #(
      .W(4)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .din_i({scl_sclk_i, sda_sdi_i, cs_n_i, address_select_pin_i}),
      .dout_o({scl_s, sda_s, cs_n_s, ad_sel_s})
   );

   // ===========================================================
   // Four-wire engine
   dsr_spi_engine u_spi (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .sclk_s_i(scl_s),
      .sdi_s_i(sda_s),
      .cs_n_s_i(cs_n_s),
      .reg_rdata_i(reg_rdata_i),
      .reg_index_o(s_index),
      .reg_wdata_o(s_wdata),
      .reg_wr_o(s_wr),
      .reg_rd_o(s_rd),
      .sdo_o(sdo_o),
      .sdo_oe_n_o(sdo_oe_n_o)
   );

   // ===========================================================
   // Edge and condition detection on synchronised levels
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   // SDA moving while SCL stays high is a frame condition, not data
   assign start_det = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det = scl_s & scl_q & ~sda_q & sda_s;
   // Disable bit or an active chip select keeps the two-wire side deaf
   assign tw_en = ~two_wire_disable_bit_i & cs_n_s;

   // ===========================================================
   // Two-wire byte engine
   always_ff @(posedge core_clk_i) begin
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      if (srst_i) begin
         state <= I_IDLE;
         kind <= K_ADDR;
         cnt <= 4'h0;
         sh <= 8'h00;
         rw <= 1'b0;
         more <= 1'b0;
         i_index <= '0;
         i_wdata <= 8'h00;
      end else if (!tw_en) begin
         state <= I_IDLE;
      end else if (start_det) begin
         state <= I_RX; // also a repeated START
         kind <= K_ADDR;
         cnt <= 4'h0;
      end else if (stop_det) begin
         state <= I_IDLE;
      end else begin
         case (state)
            I_RX: begin
               if (scl_rise) begin
                  sh <= {sh[6:0], sda_s}; // sampled only at rise
                  cnt <= cnt + 4'h1;
               end else if (scl_fall && cnt == BITS_PER_BYTE) begin
                  case (kind)
                     K_ADDR: begin
                        if (sh[7:1] == {TWO_WIRE_ADDR_HI, ad_sel_s}) begin
                           rw <= sh[0];
                           state <= I_ACK;
                           if (sh[0] != DIR_READ) begin
                              kind <= K_INDEX;
                           end
                        end else begin
                           state <= I_IDLE; // Wait for next START
                        end
                     end
                     K_INDEX: begin
                        i_index <= sh;
                        kind <= K_DATA;
                        state <= I_ACK;
                     end
                     default: begin
                        i_wdata <= sh;
                        i_wr <= 1'b1;
                        state <= I_ACK;
                     end
                  endcase
               end
            end
            I_ACK: begin
               // Index moves one cycle after the write pulse
               if (i_wr) begin
                  i_index <= i_index + 1'b1;
               end
               if (scl_fall) begin // released after ninth clock
                  cnt <= 4'h0;
                  if (rw == DIR_READ) begin
                     state <= I_FETCH;
                     i_rd <= 1'b1;
                  end else begin
                     state <= I_RX;
                  end
               end
            end
            I_FETCH: begin
               // Data arrives the cycle after the request; SCL held low meanwhile
               if (!i_rd) begin
                  sh <= reg_rdata_i;
                  i_index <= i_index + 1'b1;
                  cnt <= 4'h0;
                  state <= I_TX;
               end
            end
            I_TX: begin
               if (scl_fall) begin // data moves only with SCL low
                  if (cnt[2:0] == TX_LAST_BIT) begin
                     state <= I_MACK;
                  end else begin
                     sh <= {sh[6:0], 1'b0};
                     cnt <= cnt + 4'h1;
                  end
               end
            end
            I_MACK: begin
               if (scl_rise) begin
                  more <= ~sda_s;
               end else if (scl_fall) begin
                  if (more) begin
                     state <= I_FETCH;
                     i_rd <= 1'b1;
                  end else begin
                     state <= I_IDLE; // NACK ends driving
                  end
               end
            end
            default: begin
               state <= I_IDLE;
            end
         endcase
      end
   end

   // ===========================================================
   // Open-drain pins: only ever pull low
   assign sda_o = 1'b0;
   assign scl_o = 1'b0;
   assign sda_oe_n_o = ~((state == I_ACK) || (state == I_TX && !sh[7]));
   assign scl_oe_n_o = ~(state == I_FETCH);

   // ===========================================================
   // Register port: chip select picks the engine
   assign reg_index_o = cs_n_s ? i_index : s_index;
   assign reg_wdata_o = cs_n_s ? i_wdata : s_wdata;
   assign reg_wr_o = i_wr | s_wr;
   assign reg_rd_o = i_rd | s_rd;

   // ===========================================================
   // Checks
   property p_addr_match;
      @(posedge core_clk_i) disable iff (srst_i)
         (tw_en && !start_det && !stop_det && state == I_RX && kind == K_ADDR && scl_fall
          && cnt == BITS_PER_BYTE && sh[7:1] == {TWO_WIRE_ADDR_HI, ad_sel_s})
         |=> state == I_ACK;
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("Own address not acknowledged");

   property p_addr_miss;
      @(posedge core_clk_i) disable iff (srst_i)
         (state == I_RX && kind == K_ADDR && scl_fall && cnt == BITS_PER_BYTE
          && sh[7:1] != {TWO_WIRE_ADDR_HI, ad_sel_s})
         |=> state != I_ACK;
   endproperty
   a_addr_miss: assert property (p_addr_miss) else $error("Foreign address acknowledged");

   property p_ack_low;
      @(posedge core_clk_i) disable iff (srst_i) (state == I_ACK) |-> !sda_oe_n_o;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("Acknowledge not driven");

   property p_stop_idle;
      @(posedge core_clk_i) disable iff (srst_i) (stop_det && tw_en && !start_det) |=> state == I_IDLE;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("STOP did not free the engine");

   property p_tw_inc;
      @(posedge core_clk_i) disable iff (srst_i)
         (i_wr && tw_en && !start_det && !stop_det) |=> i_index == $past(i_index) + 1'b1;
   endproperty
   a_tw_inc: assert property (p_tw_inc) else $error("Two-wire index did not advance");

   property p_stretch;
      @(posedge core_clk_i) disable iff (srst_i) (i_rd && tw_en) |=> !scl_oe_n_o;
   endproperty
   a_stretch: assert property (p_stretch) else $error("SCL not held during fetch");

   property p_disable;
      @(posedge core_clk_i) disable iff (srst_i) !tw_en |=> (state == I_IDLE && sda_oe_n_o);
   endproperty
   a_disable: assert property (p_disable) else $error("Two-wire active while disabled");

   property p_nack_release;
      @(posedge core_clk_i) disable iff (srst_i)
         (state == I_MACK && scl_fall && !more && tw_en && !start_det && !stop_det)
         |=> sda_oe_n_o [*2];
   endproperty
   a_nack_release: assert property (p_nack_release) else $error("SDA driven after NACK");

   c_tw_write: cover property (@(posedge core_clk_i) i_wr ##[1:1000] i_wr);
   c_tw_read: cover property (@(posedge core_clk_i) state == I_MACK && more ##[1:200] state == I_FETCH);
   c_tw_restart: cover property (@(posedge core_clk_i) state == I_RX && kind == K_DATA ##1 start_det);
endmodule
`default_nettype wire

// >>> verification/dsr_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Host master model driving the shared serial pins
module dsr_master_model #(
   parameter int QTR = 13, // Two-wire quarter period in core cycles, about 385 kHz
   parameter int HALF = 4  // SPI half period in core cycles, 400 ns link clock
) (
   input wire logic core_clk_i, // Core clock
   input wire logic scl_w_i,    // Resolved clock wire
   input wire logic sda_w_i,    // Resolved data wire
   input wire logic sdo_w_i,    // Device serial output pin
   output logic clk_pin_o,      // SCL release level or SCLK level
   output logic dat_pin_o,      // SDA release level or SDI level
   output logic cs_n_o          // Chip select, active low
);
   int wait_cnt;

   // Idle lines high; SPI clock idles high too
   initial begin
      clk_pin_o = 1'b1;
      dat_pin_o = 1'b1;
      cs_n_o = 1'b1;
   end

   // All pin changes land on the falling core edge
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask

   // ==========================================================
   // Two-wire framing; start doubles as repeated start
   task automatic i2c_start();
      tick(QTR);
      dat_pin_o = 1'b1;
      tick(QTR);
      clk_pin_o = 1'b1;
      tick(QTR);
      dat_pin_o = 1'b0;
      tick(QTR);
      clk_pin_o = 1'b0;
   endtask

   task automatic i2c_stop();
      tick(QTR);
      dat_pin_o = 1'b0;
      tick(QTR);
      clk_pin_o = 1'b1;
      tick(QTR);
      dat_pin_o = 1'b1;
      tick(QTR);
   endtask

   // Eight bits plus acknowledge slot; a 1 releases the data line
   task automatic i2c_bits9(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         tick(QTR);
         dat_pin_o = tx[i];
         tick(QTR);
         clk_pin_o = 1'b1;
         wait_cnt = 0;
         // A stretching slave holds the wire low; bounded so a stuck line cannot hang us
         while (scl_w_i !== 1'b1 && wait_cnt < 200) begin
            tick(1);
            wait_cnt++;
         end
         tick(QTR);
         rx[i] = sda_w_i;
         tick(QTR);
         clk_pin_o = 1'b0;
      end
   endtask

   // ==========================================================
   // Four-wire transfer, mode 3
   task automatic spi_sel(input logic on);
      tick(HALF);
      cs_n_o = ~on;
      tick(HALF);
      dat_pin_o = 1'b1;
   endtask

   // Output sampled late in the high phase, before the next fall can move it
   task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         clk_pin_o = 1'b0;
         dat_pin_o = tx[i];
         tick(HALF);
         clk_pin_o = 1'b1;
         tick(HALF);
         rx[i] = sdo_w_i;
      end
   endtask
endmodule
`default_nettype wire

// >>> verification/dual_serial_register_slave_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench for the shared-pin register port
module dual_serial_register_slave_tb;
   import dsr_pkg::*;
   localparam int TIMEOUT = 20000;
   logic core_clk, srst, addr_sel, wdis, clk_pin, dat_pin, cs_n;
   logic sda_o, sda_oe_n, scl_o, scl_oe_n, sdo, sdo_oe_n, reg_wr, reg_rd;
   logic [REG_IDX_W-1:0] reg_index;
   logic [7:0] reg_wdata, reg_rdata;
   logic [7:0] mem [256];
   int miscompares, samples_checked, cycles, stretch_cycles;
   wire logic scl_w, sda_w, sdo_w;

   // Open-drain wires with pull-ups; released output pin floats
   // Enabled pin shows the driven value, so a wrong output level is seen on the wire
   assign scl_w = clk_pin & (scl_oe_n | scl_o);
   assign sda_w = dat_pin & (sda_oe_n | sda_o);
   assign sdo_w = (sdo_oe_n === 1'b0) ? sdo : 1'bz;

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   dsr_serial_slave dut (.core_clk_i(core_clk), .srst_i(srst), .scl_sclk_i(scl_w), .sda_sdi_i(sda_w),
      .cs_n_i(cs_n), .address_select_pin_i(addr_sel), .two_wire_disable_bit_i(wdis), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
      .reg_index_o(reg_index), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_rdata_i(reg_rdata));

   dsr_master_model host (.core_clk_i(core_clk), .scl_w_i(scl_w), .sda_w_i(sda_w), .sdo_w_i(sdo_w),
      .clk_pin_o(clk_pin), .dat_pin_o(dat_pin), .cs_n_o(cs_n));

   // Register file stand-in; read data answers in the cycle after the request
   always @(negedge core_clk) begin
      if (reg_wr === 1'b1) mem[reg_index] = reg_wdata;
      if (reg_rd === 1'b1) reg_rdata = mem[reg_index];
      if (scl_oe_n === 1'b0) stretch_cycles++;
      cycles++;
      if (cycles == TIMEOUT) begin
         miscompares++;
         end_of_test();
      end
   end

   // ==========================================================
   // Compare and report
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_i2c_write();
      logic [8:0] rx;
      addr_sel = 1'b0;
      host.i2c_start();
      host.i2c_bits9({8'hD0, 1'b1}, rx);
      chk1(rx[0], 1'b0, "addr ack");
      host.i2c_bits9({8'h10, 1'b1}, rx);
      chk1(rx[0], 1'b0, "index ack");
      host.i2c_bits9({8'hA5, 1'b1}, rx);
      chk1(rx[0], 1'b0, "data ack");
      host.i2c_bits9({8'h3C, 1'b1}, rx);
      chk1(rx[0], 1'b0, "burst ack");
      host.i2c_stop();
      chk8(mem[8'h10], 8'hA5, "first write");
      chk8(mem[8'h11], 8'h3C, "burst write");
   endtask

   task automatic t_i2c_read();
      logic [8:0] rx;
      addr_sel = 1'b1;
      mem[8'h20] = 8'h96;
      mem[8'h21] = 8'h4B;
      stretch_cycles = 0;
      host.i2c_start();
      host.i2c_bits9({8'hD2, 1'b1}, rx);
      chk1(rx[0], 1'b0, "addr ack pin high");
      host.i2c_bits9({8'h20, 1'b1}, rx);
      chk1(rx[0], 1'b0, "read index ack");
      host.i2c_start();
      host.i2c_bits9({8'hD3, 1'b1}, rx);
      chk1(rx[0], 1'b0, "read addr ack");
      host.i2c_bits9({8'hFF, 1'b0}, rx);
      chk8(rx[8:1], 8'h96, "read byte 0");
      host.i2c_bits9({8'hFF, 1'b1}, rx);
      chk8(rx[8:1], 8'h4B, "read byte 1");
      host.i2c_stop();
      chk1(sda_oe_n, 1'b1, "sda released");
      chk1(stretch_cycles != 0, 1'b1, "clock held for fetch");
   endtask

   // Wrong address, active chip select, then disabled two-wire port: all must stay silent
   task automatic t_i2c_ignored(input logic dis, input logic pin);
      logic [8:0] rx;
      wdis = dis;
      addr_sel = pin;
      host.i2c_start();
      host.i2c_bits9({8'hD0, 1'b1}, rx);
      chk1(rx[0], 1'b1, "no ack");
      host.i2c_bits9({8'h30, 1'b1}, rx);
      host.i2c_bits9({8'h77, 1'b1}, rx);
      host.i2c_stop();
      chk8(mem[8'h30], 8'h00, "no write");
   endtask

   task automatic t_spi();
      logic [7:0] rx;
      chk1(sdo_oe_n, 1'b1, "sdo idle released");
      host.spi_sel(1'b1);
      host.spi_byte(8'h05, rx);
      host.spi_byte(8'h11, rx);
      host.spi_byte(8'h22, rx);
      host.spi_sel(1'b0);
      chk8(mem[8'h05], 8'h11, "spi write");
      chk8(mem[8'h06], 8'h22, "spi burst write");
      chk1(sdo_oe_n, 1'b1, "sdo released after deselect");
      host.spi_sel(1'b1);
      host.spi_byte(8'h07, rx);
      host.spi_byte(8'h5A, rx);
      host.spi_sel(1'b0);
      chk8(mem[8'h07], 8'h5A, "spi single write");
      chk8(mem[8'h08], 8'h00, "no spill past single");
      host.spi_sel(1'b1);
      host.spi_byte(8'h85, rx);
      host.spi_byte(8'h00, rx);
      chk8(rx, 8'h11, "spi read");
      chk1(sdo_oe_n, 1'b0, "sdo driven while selected");
      host.spi_byte(8'h00, rx);
      chk8(rx, 8'h22, "spi burst read");
      host.spi_sel(1'b0);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      srst = 1'b1;
      addr_sel = 1'b0;
      wdis = 1'b0;
      reg_rdata = 8'h00;
      miscompares = 0;
      samples_checked = 0;
      cycles = 0;
      stretch_cycles = 0;
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
      repeat (5) @(negedge core_clk);
      srst = 1'b0;
      repeat (4) @(negedge core_clk);
      t_i2c_write();
      t_i2c_read();
      t_i2c_ignored(1'b0, 1'b1);
      // Own address while chip select is low: the two-wire side must stay deaf
      host.spi_sel(1'b1);
      t_i2c_ignored(1'b0, 1'b0);
      host.spi_sel(1'b0);
      t_i2c_ignored(1'b1, 1'b0);
      t_spi();
      end_of_test();
   end
endmodule
`default_nettype wire
